// file: design/rtcs_top.sv
/*
  Real-time clock core: timekeeping clock sampling and gating, prescaler
  with seconds-write reset, safe-access flag, per-minute calibration,
  a BCD time-of-day counter, keyed write enable and the alarm.
  Assumes the timekeeping clock is a slow pin sampled on clk, and that all
  control values and write strobes come from logic on clk.
*/
// Behaviour
// - Safe-access flag sets when enabled and the prescaler reaches 0x7FE0.
// - Flag clears on reset, disable, seconds write, or edge at prescaler zero.
// - Seconds write resets prescaler and half second until a falling edge.
// - Timekeeping clock is held off when disabled or frozen in debug.
// - Register access keeps working while the timekeeping clock is off.
// - Time-keeping counter writes are accepted only with write enable set.
// - Write enable sets only after key one, key two, then set of bit 3.
// - At most one cycle may pass between key two and the set write.
// - A 10-bit signed calibration value is applied once per minute.
// - Negative calibration removes pulses, positive calibration adds them.
// - Seconds write resets calibration progress but keeps its value.
// - Alarm enable bit gates the alarm; the 4-bit digit mask selects which digits match.
// - Alarm flag sets one timekeeping clock after the match is first seen.
// - Alarm with zero repeats and no endless mode clears alarm enable.
// - Repeat count decrements per alarm; zero gives a final alarm then off.
// - Endless mode keeps alarm enabled and wraps repeat count to 0xFF.
// - Safe-access flag stays set for 33 timekeeping clocks in total.
// - Mask codes select half second, second, and up to yearly intervals.
// - Every alarm sets the sticky alarm flag; software clears it.
`timescale 1ns/1ns
`default_nettype none
module rtcs_top
  import rtcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic timekeeping_clock,
  input wire logic module_enable,
  input wire logic debug_mode,
  input wire logic debug_freeze,
  input wire logic [9:0] calibration,
  input wire logic time_write,
  input wire logic [31:0] time_wdata,
  input wire logic date_write,
  input wire logic [31:0] date_wdata,
  input wire logic key_write,
  input wire logic [31:0] key_data,
  input wire logic ctrl_set_write,
  input wire logic [31:0] ctrl_set_data,
  input wire logic ctrl_clr_write,
  input wire logic [31:0] ctrl_clr_data,
  input wire logic [31:0] alarm_time,
  input wire logic [31:0] alarm_date,
  input wire logic [3:0] alarm_digit_mask,
  input wire logic alarm_cfg_write,
  input wire logic cfg_alarm_enable,
  input wire logic cfg_endless,
  input wire logic [7:0] cfg_repeat,
  input wire logic alarm_flag_clear,
  output logic [31:0] time_value_reg,
  output logic [31:0] date_value_reg,
  output logic half_second_field,
  output logic safe_access_flag,
  output logic clock_running,
  output logic time_write_enable,
  output logic alarm_enable,
  output logic [7:0] repeat_count,
  output logic alarm_flag
);

  // ****************************************
  // Functions
  // ****************************************
  // BCD increment of one two-digit field with wrap at a maximum.
  function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] vmax);
    logic [8:0] r;
    r = 9'h000;
    if (v == vmax)
      r = {1'b1, 8'h00};
    else if (v[3:0] == 4'h9)
      r = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      r = {1'b0, v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction

  // ****************************************
  // Declarations
  // ****************************************
  logic tk_meta;
  logic tk_sync;
  logic tk_prev;
  logic [14:0] presc;
  logic [14:0] next_presc;
  logic presc_rst;
  logic next_presc_rst;
  logic next_sync;
  logic [9:0] cal_left;
  logic [9:0] next_cal_left;
  logic cal_add;
  logic [9:0] cal_mag;
  logic [15:0] presc_sum;
  logic [1:0] presc_step;
  logic [8:0] sec_inc;
  logic [8:0] min_inc;
  logic [8:0] hour_inc;
  logic [31:0] next_time;
  logic [31:0] next_date;

  // ****************************************
  // Timekeeping clock sampling and gating
  // ****************************************
  // The crystal clock is slow, so sampling it beats a second domain here.
  wire tk_rise = tk_sync && !tk_prev;
  wire tk_fall = !tk_sync && tk_prev;
  wire run = module_enable && !(debug_mode && debug_freeze);
  wire seconds_write = time_write && time_write_enable;
  wire presc_hold = seconds_write || presc_rst;
  wire tick = tk_rise && run && !presc_hold;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tk_meta <= 1'b0;
      tk_sync <= 1'b0;
      tk_prev <= 1'b0;
      clock_running <= 1'b0;
    end
    else
    begin
      tk_meta <= timekeeping_clock;
      tk_sync <= tk_meta;
      tk_prev <= tk_sync;
      clock_running <= run;
    end
  end

  // ****************************************
  // Prescaler and its seconds-write reset
  // ****************************************
  // Held reset is released only by a falling edge, so the first count
  // after a seconds write comes from a complete crystal period.
  assign next_presc_rst = seconds_write ? 1'b1 :
                          tk_fall ? 1'b0 : presc_rst;

  assign presc_step = (cal_left == CAL_NONE) ? 2'h1 :
                      cal_add ? 2'h2 : 2'h0;
  assign presc_sum = {1'b0, presc} + {14'h0000, presc_step};
  wire sec_roll = tick && presc_sum[15];
  wire min_roll = sec_roll && sec_inc[8];

  assign next_presc = presc_hold ? PRESC_RESET :
                      tick ? presc_sum[14:0] : presc;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      presc <= PRESC_RESET;
      presc_rst <= 1'b0;
    end
    else
    begin
      presc <= next_presc;
      presc_rst <= next_presc_rst;
    end
  end

  assign half_second_field = presc[PRESC_HALF_BIT];

  // ****************************************
  // Safe-access flag
  // ****************************************
  // Set at 0x7FE0, held through the rollover to zero, then cleared on the
  // next edge that finds the prescaler at zero: 33 timekeeping clocks.
  wire sync_clear = !module_enable || seconds_write ||
                    (tick && presc == PRESC_ZERO);
  wire sync_set = module_enable && presc == PRESC_SYNC_SET;

  assign next_sync = sync_clear ? 1'b0 :
                     sync_set ? 1'b1 : safe_access_flag;

  always_ff @(posedge clk)
  begin
    if (rst)
      safe_access_flag <= 1'b0;
    else
      safe_access_flag <= next_sync;
  end

  // ****************************************
  // Calibration
  // ****************************************
  // The adjustment starts at each minute rollover. A positive value steps
  // the prescaler twice per edge, a negative one stalls it for one edge,
  // per pulse. The largest magnitude, 512, still fits the counter.
  assign cal_mag = calibration[CAL_WIDTH-1] ?
                   10'(~calibration + 10'h001) : calibration;

  assign next_cal_left = seconds_write ? CAL_NONE :
                         min_roll ? cal_mag :
                         (tick && cal_left != CAL_NONE) ?
                         cal_left - 10'h001 : cal_left;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cal_left <= CAL_NONE;
      cal_add <= 1'b0;
    end
    else
    begin
      cal_left <= next_cal_left;
      if (min_roll)
        cal_add <= !calibration[CAL_WIDTH-1];
    end
  end

  // ****************************************
  // Time-of-day and date registers
  // ****************************************
  // Only seconds, minutes and hours count here; the date is held as
  // written and carries no day rollover.
  assign sec_inc = bcd_inc(time_value_reg[SEC_HI:SEC_LO], SEC_MAX);
  assign min_inc = bcd_inc(time_value_reg[MIN_HI:MIN_LO], MIN_MAX);
  assign hour_inc = bcd_inc(time_value_reg[HOUR_HI:HOUR_LO], HOUR_MAX);

  assign next_time =
    seconds_write ? time_wdata :
    !sec_roll ? time_value_reg :
    !sec_inc[8] ? {time_value_reg[31:16], sec_inc[7:0], 8'h00} :
    !min_inc[8] ? {time_value_reg[31:24], min_inc[7:0], 16'h0000} :
    {hour_inc[7:0], 24'h000000};

  assign next_date = (date_write && time_write_enable) ?
                     date_wdata : date_value_reg;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      time_value_reg <= TIME_RESET;
      date_value_reg <= DATE_RESET;
    end
    else
    begin
      time_value_reg <= next_time;
      date_value_reg <= next_date;
    end
  end

  // ****************************************
  // Keyed write enable
  // ****************************************
  wire other_write = time_write || date_write || alarm_cfg_write;

  rtcs_unlock u_unlock (
    .clk(clk),
    .rst(rst),
    .key_write(key_write),
    .key_data(key_data),
    .ctrl_set_write(ctrl_set_write),
    .ctrl_set_data(ctrl_set_data),
    .ctrl_clr_write(ctrl_clr_write),
    .ctrl_clr_data(ctrl_clr_data),
    .other_write(other_write),
    .time_write_enable(time_write_enable)
  );

  // ****************************************
  // Alarm
  // ****************************************
  wire half_start = (presc[PRESC_HALF_BIT-1:0] == 14'h0000);
  wire sec_start = (presc == PRESC_ZERO);

  rtcs_alarm u_alarm (
    .clk(clk),
    .rst(rst),
    .tick(tick),
    .half_start(half_start),
    .sec_start(sec_start),
    .time_now(time_value_reg),
    .date_now(date_value_reg),
    .alarm_time(alarm_time),
    .alarm_date(alarm_date),
    .alarm_digit_mask(alarm_digit_mask),
    .alarm_cfg_write(alarm_cfg_write),
    .cfg_alarm_enable(cfg_alarm_enable),
    .cfg_endless(cfg_endless),
    .cfg_repeat(cfg_repeat),
    .alarm_flag_clear(alarm_flag_clear),
    .alarm_enable(alarm_enable),
    .repeat_count(repeat_count),
    .alarm_flag(alarm_flag)
  );

endmodule
`default_nettype wire

// file: design/rtcs_pkg.sv
/*
  Shared constants of the real-time clock block: prescaler values, unlock
  keys, register field positions, alarm mask codes and reset values.
  Assumes every design file imports the whole package.
*/
package rtcs_pkg;

  // ****************************************
  // Prescaler
  // ****************************************
  localparam logic [14:0] PRESC_SYNC_SET = 15'h7fe0;
  localparam logic [14:0] PRESC_ZERO = 15'h0000;
  localparam logic [14:0] PRESC_RESET = 15'h0000;
  localparam int PRESC_HALF_BIT = 14;

  // ****************************************
  // Keyed unlock
  // ****************************************
  localparam logic [31:0] UNLOCK_KEY1 = 32'haa996655;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h556699aa;
  localparam logic [31:0] WREN_SET_VALUE = 32'h00000008;
  localparam int WREN_BIT = 3;
  localparam logic [1:0] UNLOCK_GAP_CYCLES = 2'h1;

  // ****************************************
  // Time and date field positions
  // ****************************************
  localparam int SEC_LO = 8;
  localparam int SEC_HI = 15;
  localparam int MIN_LO = 16;
  localparam int MIN_HI = 23;
  localparam int HOUR_LO = 24;
  localparam int HOUR_HI = 31;
  localparam logic [7:0] SEC_MAX = 8'h59;
  localparam logic [7:0] MIN_MAX = 8'h59;
  localparam logic [7:0] HOUR_MAX = 8'h23;
  localparam logic [31:0] TIME_RESET = 32'h00000000;
  localparam logic [31:0] DATE_RESET = 32'h00010100;

  // ****************************************
  // Calibration
  // ****************************************
  localparam int CAL_WIDTH = 10;
  localparam logic [9:0] CAL_NONE = 10'h000;

  // ****************************************
  // Alarm
  // ****************************************
  localparam logic [3:0] ALARM_DIGIT_MASK_HALF_SEC = 4'h0;
  localparam logic [3:0] ALARM_DIGIT_MASK_SEC = 4'h1;
  localparam logic [3:0] ALARM_DIGIT_MASK_10_SEC = 4'h2;
  localparam logic [3:0] ALARM_DIGIT_MASK_MIN = 4'h3;
  localparam logic [3:0] ALARM_DIGIT_MASK_10_MIN = 4'h4;
  localparam logic [3:0] ALARM_DIGIT_MASK_HOUR = 4'h5;
  localparam logic [3:0] ALARM_DIGIT_MASK_DAY = 4'h6;
  localparam logic [3:0] ALARM_DIGIT_MASK_WEEK = 4'h7;
  localparam logic [3:0] ALARM_DIGIT_MASK_MONTH = 4'h8;
  localparam logic [3:0] ALARM_DIGIT_MASK_YEAR = 4'h9;
  localparam logic [7:0] REPEAT_RESET = 8'h00;
  localparam logic [7:0] REPEAT_ZERO = 8'h00;
  localparam logic [7:0] REPEAT_WRAP = 8'hff;

endpackage

// file: design/rtcs_unlock.sv
/*
  Keyed write-enable for the time-keeping registers: two keys on the key
  port, then a set write of the enable bit within the allowed gap.
  Assumes all bus write strobes are one-cycle pulses on clk.
*/
`timescale 1ns/1ns
`default_nettype none
module rtcs_unlock
  import rtcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic key_write,
  input wire logic [31:0] key_data,
  input wire logic ctrl_set_write,
  input wire logic [31:0] ctrl_set_data,
  input wire logic ctrl_clr_write,
  input wire logic [31:0] ctrl_clr_data,
  input wire logic other_write,
  output logic time_write_enable
);

  // ****************************************
  // Sequence state
  // ****************************************
  typedef enum logic [2:0] {
    RTCS_UL_IDLE = 3'b001,
    RTCS_UL_KEY1 = 3'b010,
    RTCS_UL_KEY2 = 3'b100
  } rtcs_ul_state_t;

  rtcs_ul_state_t state;
  rtcs_ul_state_t next_state;
  logic [1:0] gap;
  logic next_wren;

  wire key1_hit = key_write && (key_data == UNLOCK_KEY1);
  wire key2_hit = key_write && (key_data == UNLOCK_KEY2);
  wire set_hit = ctrl_set_write && (ctrl_set_data == WREN_SET_VALUE);
  wire any_write = key_write || ctrl_set_write || ctrl_clr_write ||
                   other_write;
  wire unlock_ok = (state == RTCS_UL_KEY2) && set_hit;
  wire clr_hit = ctrl_clr_write && ctrl_clr_data[WREN_BIT];

  always_comb
  begin
    next_state = state;
    case (state)
      RTCS_UL_IDLE:
        if (key1_hit)
          next_state = RTCS_UL_KEY1;
      RTCS_UL_KEY1:
        if (key2_hit)
          next_state = RTCS_UL_KEY2;
        else if (key1_hit)
          next_state = RTCS_UL_KEY1;
        else if (any_write)
          next_state = RTCS_UL_IDLE;
      RTCS_UL_KEY2:
        if (any_write || gap == UNLOCK_GAP_CYCLES)
          next_state = key1_hit ? RTCS_UL_KEY1 : RTCS_UL_IDLE;
      default:
        next_state = RTCS_UL_IDLE;
    endcase
  end

  // Clearing always wins so software can relock in any state.
  assign next_wren = clr_hit ? 1'b0 :
                     unlock_ok ? 1'b1 : time_write_enable;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= RTCS_UL_IDLE;
      gap <= 2'h0;
      time_write_enable <= 1'b0;
    end
    else
    begin
      state <= next_state;
      gap <= (state == RTCS_UL_KEY2) ? gap + 2'h1 : 2'h0;
      time_write_enable <= next_wren;
    end
  end

endmodule
`default_nettype wire

// file: design/rtcs_alarm.sv
/*
  Alarm comparator with digit mask, one-time, repeat and endless modes
  and the sticky alarm flag. Assumes tick is a one-cycle pulse per
  timekeeping clock edge and that the time and date inputs are registered.
*/
`timescale 1ns/1ns
`default_nettype none
module rtcs_alarm
  import rtcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic half_start,
  input wire logic sec_start,
  input wire logic [31:0] time_now,
  input wire logic [31:0] date_now,
  input wire logic [31:0] alarm_time,
  input wire logic [31:0] alarm_date,
  input wire logic [3:0] alarm_digit_mask,
  input wire logic alarm_cfg_write,
  input wire logic cfg_alarm_enable,
  input wire logic cfg_endless,
  input wire logic [7:0] cfg_repeat,
  input wire logic alarm_flag_clear,
  output logic alarm_enable,
  output logic [7:0] repeat_count,
  output logic alarm_flag
);

  logic [31:0] tmask;
  logic [31:0] dmask;
  logic endless;
  logic cmp_prev;
  logic pending;

  assign tmask = (alarm_digit_mask == ALARM_DIGIT_MASK_10_SEC) ? 32'h00000f00 :
                 (alarm_digit_mask == ALARM_DIGIT_MASK_MIN) ? 32'h0000ff00 :
                 (alarm_digit_mask == ALARM_DIGIT_MASK_10_MIN) ? 32'h000fff00 :
                 (alarm_digit_mask == ALARM_DIGIT_MASK_HOUR) ? 32'h00ffff00 :
                 (alarm_digit_mask >= ALARM_DIGIT_MASK_DAY &&
                  alarm_digit_mask <= ALARM_DIGIT_MASK_YEAR) ? 32'hffffff00 :
                 32'h00000000;
  assign dmask = (alarm_digit_mask == ALARM_DIGIT_MASK_WEEK) ? 32'h0000000f :
                 (alarm_digit_mask == ALARM_DIGIT_MASK_MONTH) ? 32'h0000ff00 :
                 (alarm_digit_mask == ALARM_DIGIT_MASK_YEAR) ? 32'h00ffff00 :
                 32'h00000000;

  wire cmp = (((time_now ^ alarm_time) & tmask) == 32'h0) &&
             (((date_now ^ alarm_date) & dmask) == 32'h0);
  wire hit = (alarm_digit_mask == ALARM_DIGIT_MASK_HALF_SEC) ? half_start :
             (alarm_digit_mask == ALARM_DIGIT_MASK_SEC) ? sec_start :
             (cmp && !cmp_prev);
  wire fire = tick && pending;
  wire last = (repeat_count == REPEAT_ZERO);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      alarm_enable <= 1'b0;
      endless <= 1'b0;
      repeat_count <= REPEAT_RESET;
      cmp_prev <= 1'b0;
      pending <= 1'b0;
      alarm_flag <= 1'b0;
    end
    else
    begin
      if (tick)
        cmp_prev <= cmp;
      if (alarm_cfg_write)
      begin
        alarm_enable <= cfg_alarm_enable;
        endless <= cfg_endless;
        repeat_count <= cfg_repeat;
        pending <= 1'b0;
      end
      else if (tick)
      begin
        pending <= alarm_enable && hit && !fire;
        if (fire)
        begin
          repeat_count <= repeat_count - 8'h01;
          if (last && !endless)
          begin
            alarm_enable <= 1'b0;
            repeat_count <= REPEAT_ZERO;
          end
        end
      end
      // The event wins over a clear arriving in the same cycle.
      if (fire)
        alarm_flag <= 1'b1;
      else if (alarm_flag_clear)
        alarm_flag <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// file: bench/rtcs_top_assertions.sv
/*
  Concurrent checks on the ports of rtcs_top, bound to every instance.
  Assumes one clock domain with a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module rtcs_top_assertions
  import rtcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic module_enable,
  input wire logic debug_mode,
  input wire logic debug_freeze,
  input wire logic time_write,
  input wire logic [31:0] time_wdata,
  input wire logic key_write,
  input wire logic [31:0] key_data,
  input wire logic ctrl_set_write,
  input wire logic [31:0] ctrl_set_data,
  input wire logic alarm_cfg_write,
  input wire logic alarm_flag_clear,
  input wire logic [31:0] time_value_reg,
  input wire logic half_second_field,
  input wire logic safe_access_flag,
  input wire logic clock_running,
  input wire logic time_write_enable,
  input wire logic alarm_enable,
  input wire logic [7:0] repeat_count,
  input wire logic alarm_flag
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  run_gate_a:
    assert property (!$past(rst) |-> clock_running ==
      $past(module_enable && !(debug_mode && debug_freeze)))
    else $error("clock gate follows wrong inputs");
  sync_off_a:
    assert property (!module_enable |=> !safe_access_flag)
    else $error("safe flag high while disabled");
  sec_write_a:
    assert property (time_write && time_write_enable |=> !safe_access_flag
      && !half_second_field && time_value_reg == $past(time_wdata))
    else $error("accepted time write not applied");
  write_lock_a:
    assert property (time_write && !time_write_enable && !clock_running
      |=> $stable(time_value_reg))
    else $error("locked time write changed time");
  unlock_set_a:
    assert property ($rose(time_write_enable) |->
      $past(ctrl_set_write && ctrl_set_data == WREN_SET_VALUE))
    else $error("write enable rose without set write");
  unlock_gap_a:
    assert property ($rose(time_write_enable) |->
      $past(key_write && key_data == UNLOCK_KEY2, 2) ||
      $past(key_write && key_data == UNLOCK_KEY2, 3))
    else $error("write enable rose outside key window");
  flag_sticky_a:
    assert property (alarm_flag && !alarm_flag_clear |=> alarm_flag)
    else $error("alarm flag dropped without clear");
  one_shot_a:
    assert property ($fell(alarm_enable) && !$past(alarm_cfg_write) |->
      $past(repeat_count) == REPEAT_ZERO ##[0:1] alarm_flag)
    else $error("alarm disabled with repeats left");
  repeat_step_a:
    assert property (!$past(rst) && !$past(alarm_cfg_write) &&
      repeat_count != $past(repeat_count) |->
      repeat_count == $past(repeat_count) - 8'h01 ##[0:1] alarm_flag)
    else $error("repeat count moved wrongly");
  endless_a:
    assert property ($past(repeat_count) == REPEAT_ZERO &&
      repeat_count == REPEAT_WRAP && !$past(alarm_cfg_write) |-> alarm_enable)
    else $error("endless wrap lost alarm enable");
endmodule

bind rtcs_top rtcs_top_assertions rtcs_top_assertions_i (.*);
`default_nettype wire

// file: bench/tb.sv
/*
  Self-checking bench for rtcs_top: keyed unlock cases, alarm digit
  masks and repeat modes, clock gating and one full second of counting.
  Assumes the design package and the checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module tb
  import rtcs_pkg::*;
;
  // ****************
  // Signals
  // ****************
  logic clk, rst, timekeeping_clock, module_enable, debug_mode;
  logic debug_freeze, time_write, date_write, key_write, ctrl_set_write;
  logic ctrl_clr_write, alarm_cfg_write, cfg_alarm_enable, cfg_endless;
  logic alarm_flag_clear, half_second_field, safe_access_flag;
  logic clock_running, time_write_enable, alarm_enable, alarm_flag;
  logic [9:0] calibration;
  logic [31:0] time_wdata, date_wdata, key_data, ctrl_set_data;
  logic [31:0] ctrl_clr_data, alarm_time, alarm_date;
  logic [31:0] time_value_reg, date_value_reg, tv, dv, cm, dm;
  logic [31:0] kk = UNLOCK_KEY1 ^ UNLOCK_KEY2;
  logic [3:0] alarm_digit_mask;
  logic [7:0] cfg_repeat, repeat_count;
  int unsigned n;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  int ph = 0;
  int t0, code;

  rtcs_top rtcs_top_i (.*);

  // ****************
  // Tasks
  // ****************
  task check(input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task step(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] bcd(input int v);
    return 8'((v / 10) * 16 + v % 10);
  endfunction

  task wr_td(input logic [31:0] t, d);
    time_write = 1'b1;
    date_write = 1'b1;
    time_wdata = t;
    date_wdata = d;
    step;
    time_write = 1'b0;
    date_write = 1'b0;
  endtask

  task cfg(input logic e, c, input logic [7:0] r);
    alarm_cfg_write = 1'b1;
    alarm_flag_clear = 1'b1;
    cfg_alarm_enable = e;
    cfg_endless = c;
    cfg_repeat = r;
    step;
    alarm_cfg_write = 1'b0;
    alarm_flag_clear = 1'b0;
  endtask

  // Keys and set data are given as xor offsets from the good values.
  task unlock(input logic [31:0] x1, x2, xs, input int gap, input logic e);
    ctrl_clr_write = 1'b1;
    step;
    ctrl_clr_write = 1'b0;
    key_write = 1'b1;
    key_data = UNLOCK_KEY1 ^ x1;
    step;
    key_data = UNLOCK_KEY2 ^ x2;
    step;
    key_write = 1'b0;
    if (gap > 1)
      step(gap - 1);
    ctrl_set_write = 1'b1;
    ctrl_set_data = WREN_SET_VALUE ^ xs;
    step;
    ctrl_set_write = 1'b0;
    check(time_write_enable, e);
  endtask

  // ****************
  // Clocks
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // The crystal pin runs at a third of clk so one second fits the run.
  always @(posedge clk)
  begin
    #1;
    ph = (ph == 2) ? 0 : ph + 1;
    timekeeping_clock = (ph != 2);
    cyc++;
    if (cyc == 100000)
    begin
      fails++;
      wrap_up;
    end
  end

  // ****************
  // Sequence
  // ****************
  initial
  begin
    {rst, timekeeping_clock, module_enable, debug_mode} = 4'h8;
    {debug_freeze, time_write, date_write, key_write} = 4'h0;
    {ctrl_set_write, ctrl_clr_write, alarm_cfg_write} = 3'h0;
    {cfg_alarm_enable, cfg_endless, alarm_flag_clear} = 3'h0;
    {time_wdata, date_wdata, key_data, ctrl_set_data} = 128'h0;
    {alarm_time, alarm_date, cfg_repeat, alarm_digit_mask} = 76'h0;
    ctrl_clr_data = WREN_SET_VALUE;
    n = $urandom(32'h0f6b);
    calibration = 10'(n);
    step(6);
    rst = 1'b0;
    check(clock_running, 1'b0);
    unlock(0, 0, 0, 1, 1'b1);
    unlock(0, 0, 0, 2, 1'b1);
    unlock(0, 0, 0, 3, 1'b0);
    unlock(kk, kk, 0, 1, 1'b0);
    unlock(0, n | 32'h1, 0, 1, 1'b0);
    unlock(0, 0, 32'h4, 1, 1'b0);
    wr_td(32'h12345600, 32'h0);
    check(time_value_reg, TIME_RESET);
    check(date_value_reg, DATE_RESET);
    unlock(0, 0, 0, 1, 1'b1);
    wr_td(32'h23595800, 32'h0);
    check(time_value_reg, 32'h23595800);
    module_enable = 1'b1;
    debug_mode = 1'b1;
    debug_freeze = 1'b1;
    step(2);
    check(clock_running, 1'b0);
    debug_freeze = 1'b0;
    step(2);
    check(clock_running, 1'b1);
    for (code = 2; code < 10; code++)
    begin
      n = $urandom;
      cm = code < 3 ? 32'hf00 : code < 4 ? 32'hff00 : code < 5 ? 32'hfff00 :
        code < 6 ? 32'hffff00 : 32'hffffff00;
      dm = code == 7 ? 32'hf : code == 8 ? 32'hff00 :
        code == 9 ? 32'hffff00 : 32'h0;
      tv = {bcd(n % 24), bcd(n / 24 % 60), bcd(n % 6 * 10 + n / 7 % 9 + 1),
        8'h00};
      dv = {8'h00, bcd(n % 12 + 1), bcd(n % 28 + 1), 8'(n % 7)};
      wr_td(32'h0, 32'h0);
      alarm_time = tv & cm | ~tv & ~cm;
      alarm_date = dv & dm | ~dv & ~dm;
      alarm_digit_mask = 4'(code);
      cfg(1'b1, code == 9, code == 5 ? 8'h03 : 8'h00);
      step(12);
      check(alarm_flag, 1'b0);
      wr_td(tv, dv);
      t0 = cyc;
      check(date_value_reg, dv);
      while (alarm_flag !== 1'b1)
        step;
      check(cyc - t0 > 3 && cyc - t0 < 24, 1'b1);
      step;
      check(alarm_enable, code == 5 || code == 9);
      check(repeat_count, code == 5 ? 2 : code == 9 ? 8'hff : 0);
    end
    alarm_digit_mask = ALARM_DIGIT_MASK_HALF_SEC;
    wr_td(32'h0, 32'h0);
    t0 = cyc;
    cfg(1'b1, 1'b0, 8'h01);
    while (half_second_field !== 1'b1)
      step;
    check(cyc - t0 > 49140 && cyc - t0 < 49170, 1'b1);
    step(12);
    check({alarm_flag, alarm_enable, repeat_count}, 10'h200);
    alarm_flag_clear = 1'b1;
    step;
    alarm_flag_clear = 1'b0;
    while (safe_access_flag !== 1'b1)
      step;
    check(cyc - t0 > 98196 && cyc - t0 < 98226, 1'b1);
    t0 = cyc;
    while (time_value_reg[15:8] !== 8'h01)
      step;
    check(safe_access_flag, 1'b1);
    while (safe_access_flag !== 1'b0)
      step;
    check(cyc - t0 > 95 && cyc - t0 < 103, 1'b1);
    step(12);
    check({alarm_flag, alarm_enable}, 2'h0);
    ctrl_clr_write = 1'b1;
    step;
    ctrl_clr_write = 1'b0;
    check(time_write_enable, 1'b0);
    wrap_up;
  end
endmodule
`default_nettype wire
